// ===== bench/pprc_ctrl_asserts.sv
// Checker for the power, reset and test-port control block.
// Sees only ports of pprc_ctrl; the bind stands after the module.
`timescale 1ns/1ps
module pprc_ctrl_asserts
    import pprc_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic power_good_i,
    input wire logic reset_n_i,
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic ack_o,
    input wire logic chip_select_n_i,
    input wire logic flash_enable_o,
    input wire logic flash_lowpower_o,
    input wire logic write_strobe_ctl_n_i,
    input wire logic flash_write_n_o,
    input wire logic tp_pin_config_i,
    input wire logic tp_array_enable_i,
    input wire logic tp_active_o,
    input wire logic tdo_oe_n_o,
    input wire logic flash_busy_i,
    input wire logic isp_status_pin_o,
    input wire logic device_ready_o
);
    // ****************************************
    // Helper logic and assertions
    // ****************************************
    logic rst_any;
    int   run_cnt;
    assign rst_any = rst_i | ~power_good_i;
    // Saturates so a long run cannot wrap it
    always_ff @(posedge clk_i)
    begin
        if (rst_any || !reset_n_i)
            run_cnt <= 0;
        else if (run_cnt < 1000)
            run_cnt <= run_cnt + 1;
    end
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_any);
    property p_ack_pulse;
        ack_o |=> !ack_o;
    endproperty
    a_ack_pulse: assert property (p_ack_pulse) else $error("ack held too long");
    property p_ack_answer;
        cyc_i && stb_i && !ack_o |=> ack_o;
    endproperty
    a_ack_answer: assert property (p_ack_answer) else $error("ack missing");
    property p_cs_off;
        chip_select_n_i [*4] |=> !flash_enable_o && flash_lowpower_o;
    endproperty
    a_cs_off: assert property (p_cs_off) else $error("flash on while deselected");
    property p_ready_wait;
        $rose(device_ready_o) |-> run_cnt >= PPRC_RECOVERY_CYC;
    endproperty
    a_ready_wait: assert property (p_ready_wait) else $error("ready too early");
    property p_tp_or;
        (tp_pin_config_i || tp_array_enable_i) [*4] |=> tp_active_o;
    endproperty
    a_tp_or: assert property (p_tp_or) else $error("test port not on");
    property p_tdo_cmd;
        !tdo_oe_n_o |-> tp_active_o || $past(tp_active_o);
    endproperty
    a_tdo_cmd: assert property (p_tdo_cmd) else $error("data out driven off port");
    property p_busy;
        flash_busy_i [*3] |=> !isp_status_pin_o;
    endproperty
    a_busy: assert property (p_busy) else $error("status high while busy");
    property p_wr_pass;
        (!write_strobe_ctl_n_i && !chip_select_n_i && device_ready_o) [*4] |=> !flash_write_n_o;
    endproperty
    a_wr_pass: assert property (p_wr_pass) else $error("write strobe lost");
endmodule
bind pprc_ctrl pprc_ctrl_asserts pprc_ctrl_asserts_i (.*);

// ===== bench/pprc_far_model.sv
// Model of the reset pin driver and the test-port programmer outside the block.
// Assumes the bench requests pulses and commands as levels sampled on clk_i.
`timescale 1ns/1ps
module pprc_far_model
#(
    parameter int POR_W  = 40,
    parameter int WARM_W = 4
)
(
    input  wire logic clk_i,
    input  wire logic por_i,
    input  wire logic warm_i,
    input  wire logic cmd_i,
    input  wire logic ext_i,
    output logic      reset_n_o,
    output logic      tp_enable_cmd_o,
    output logic      tp_ext_cmd_o
);
    // ****************************************
    // Reset pin and programmer commands
    // ****************************************
    int cnt = 0;
    // Power-on needs a far longer low pulse than a warm reset
    always @(posedge clk_i)
    begin
        if (por_i)
            cnt <= POR_W;
        else if (warm_i && cnt == 0)
            cnt <= WARM_W;
        else if (cnt > 0)
            cnt <= cnt - 1;
    end
    assign reset_n_o       = (cnt == 0) && !por_i;
    // Extension pins are only ever asked for with the enabling command
    assign tp_enable_cmd_o = cmd_i;
    assign tp_ext_cmd_o    = cmd_i & ext_i;
endmodule

// ===== bench/tb_pprc_ctrl.sv
// Self-checking bench for the power, reset and test-port control block.
// Assumes the far-side model and the bound checker are compiled with it.
`timescale 1ns/1ps
module tb_pprc_ctrl;
    import pprc_pkg::*;
    // ****************************************
    // Signals, tasks and sequence
    // ****************************************
    logic        clk_i = 1'b0, rst_i = 1'b1, power_good_i = 1'b0;
    logic        cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0;
    logic [3:0]  adr_i = 4'h0, sel_i = 4'h0;
    logic [31:0] dat_i = 32'h0, dat_o, rd;
    logic        write_strobe_ctl_n_i = 1'b1, read_strobe_ctl_n_i = 1'b0;
    logic        third_control_input_i = 1'b1, port_d_pin0_i = 1'b1, port_c_pin7_i = 1'b1;
    logic        array_clock_input_i = 1'b1, chip_select_n_i = 1'b0, blank_device_i = 1'b0;
    logic        tp_pin_config_i = 1'b0, tp_array_enable_i = 1'b0;
    logic        flash_busy_i = 1'b0, flash_error_i = 1'b0, flash_sector_any_i = 1'b0;
    logic        por = 1'b1, warm = 1'b0, cmd = 1'b0, ext = 1'b0;
    logic        reset_n_i, tp_enable_cmd_i, tp_ext_cmd_i, ack_o, mcell_clock_o;
    logic        array_standby_o, array_slow_o, array_valid_o, flash_enable_o;
    logic        flash_lowpower_o, flash_read_array_o, flash_sector_block_o;
    logic        flash_write_n_o, flash_read_n_o, tp_active_o, tdo_oe_n_o;
    logic        isp_status_pin_o, isp_error_pin_o, isp_stat_oe_n_o, device_ready_o;
    logic [7:0]  ra, rb;
    pprc_array_in_s array_in_o;
    int          mismatches = 0, samples_checked = 0, n;
    pprc_ctrl pprc_ctrl_i (.*);
    pprc_far_model pprc_far_model_i (.clk_i(clk_i), .por_i(por), .warm_i(warm), .cmd_i(cmd),
        .ext_i(ext), .reset_n_o(reset_n_i), .tp_enable_cmd_o(tp_enable_cmd_i),
        .tp_ext_cmd_o(tp_ext_cmd_i));
    always #2.5 clk_i = ~clk_i;
    task automatic print_verdict;
        $display("checks %0d mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
        samples_checked++;
        if (g !== e)
        begin
            mismatches++;
            $display("unexpected %s expected %h seen %h", nm, e, g);
        end
    endtask
    // Slave answers in one cycle, but the master never relies on that
    task automatic wb(input logic w, input logic [3:0] a, input logic [7:0] d,
                      input logic [3:0] s);
        int k;
        @(posedge clk_i);
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i  <= w;
        adr_i <= a;
        sel_i <= s;
        dat_i <= {24'h0, d};
        k = 0;
        do
        begin
            @(posedge clk_i);
            k++;
        end
        while (ack_o !== 1'b1 && k < 40);
        cmp("ack", 32'h1, 32'(ack_o));
        rd = dat_o;
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
    endtask
    task automatic rd_chk(input logic [3:0] a, input logic [7:0] e);
        wb(1'b0, a, 8'h00, 4'hF);
        cmp("register", {24'h0, e}, rd);
    endtask
    task automatic settle;
        repeat (8) @(posedge clk_i);
    endtask
    task automatic wait_ready;
        repeat (8) @(posedge clk_i);
        n = 0;
        while (device_ready_o !== 1'b1 && n < 400)
        begin
            @(posedge clk_i);
            n++;
        end
        cmp("ready", 32'h1, 32'(device_ready_o));
    endtask
    task automatic power_up;
        power_good_i <= 1'b0;
        rst_i <= 1'b1;
        por <= 1'b1;
        write_strobe_ctl_n_i <= 1'b1;
        repeat (6) @(posedge clk_i);
        cmp("sector block", 32'h1, 32'(flash_sector_block_o));
        cmp("flash write", 32'h1, 32'(flash_write_n_o));
        rst_i <= 1'b0;
        power_good_i <= 1'b1;
        por <= 1'b0;
        wait_ready();
    endtask
    initial
    begin
        void'($urandom(32'hB2309674));
        power_up();
        rd_chk(PPRC_ADDR_REG_A, 8'h00);
        rd_chk(PPRC_ADDR_REG_B, 8'h00);
        cmp("read array", 32'h1, 32'(flash_read_array_o));
        cmp("array valid", 32'h1, 32'(array_valid_o));
        cmp("sector block", 32'h0, 32'(flash_sector_block_o));
        $display("test power-up done");
        write_strobe_ctl_n_i <= 1'b0;
        for (int i = 0; i < 8; i++)
        begin
            ra = (i == 0) ? 8'h30 : (i == 1) ? 8'h00 : 8'($urandom) & 8'h30;
            rb = (i == 0) ? 8'h7C : (i == 1) ? 8'h00 : 8'($urandom) & PPRC_MASK_REG_B;
            wb(1'b1, PPRC_ADDR_REG_A, ra, 4'h1);
            wb(1'b1, PPRC_ADDR_REG_B, rb, 4'h1);
            settle();
            cmp("array", {26'h0, ~rb[2], ~rb[3], ~rb[4], ~rb[5], ~rb[6], ~ra[4]},
                32'(array_in_o));
            cmp("mcell clock", 32'(!ra[5]), 32'(mcell_clock_o));
            cmp("flash write", 32'h0, 32'(flash_write_n_o));
            cmp("flash read", 32'h0, 32'(flash_read_n_o));
            rd_chk(PPRC_ADDR_REG_A, ra);
            rd_chk(PPRC_ADDR_REG_B, rb);
        end
        wb(1'b1, PPRC_ADDR_REG_B, 8'h04, 4'h2);
        rd_chk(PPRC_ADDR_REG_B, rb);
        wb(1'b1, 4'h1, 8'hFF, 4'h1);
        rd_chk(4'h1, 8'h00);
        $display("test blocking done");
        wb(1'b1, PPRC_ADDR_REG_B, 8'h00, 4'h1);
        wb(1'b1, PPRC_ADDR_REG_A, 8'h08, 4'h1);
        repeat (PPRC_STANDBY_CYC + 8) @(posedge clk_i);
        cmp("standby", 32'h1, 32'(array_standby_o));
        third_control_input_i <= 1'b0;
        n = 0;
        repeat (8)
        begin
            @(posedge clk_i);
            if (array_slow_o === 1'b1)
                n = 1;
        end
        cmp("slow", 32'h1, 32'(n));
        wb(1'b1, PPRC_ADDR_REG_A, 8'h00, 4'h1);
        // Long enough that standby would have come back if fast mode were ignored
        repeat (PPRC_STANDBY_CYC + 8) @(posedge clk_i);
        cmp("standby", 32'h0, 32'(array_standby_o));
        $display("test standby done");
        wb(1'b1, PPRC_ADDR_REG_B, 8'h44, 4'h1);
        wb(1'b1, PPRC_ADDR_CTRL, 8'h01, 4'h1);
        write_strobe_ctl_n_i <= 1'b1;
        warm <= 1'b1;
        rst_i <= 1'b1;
        @(posedge clk_i);
        warm <= 1'b0;
        rst_i <= 1'b0;
        repeat (4) @(posedge clk_i);
        cmp("ready", 32'h0, 32'(device_ready_o));
        cmp("array valid", 32'h1, 32'(array_valid_o));
        wait_ready();
        rd_chk(PPRC_ADDR_REG_B, 8'h44);
        rd_chk(PPRC_ADDR_CTRL, 8'h00);
        power_up();
        rd_chk(PPRC_ADDR_REG_B, 8'h00);
        $display("test resets done");
        third_control_input_i <= 1'b1;
        chip_select_n_i <= 1'b1;
        settle();
        cmp("flash enable", 32'h0, 32'(flash_enable_o));
        cmp("flash low power", 32'h1, 32'(flash_lowpower_o));
        cmp("array", 32'h1F, 32'(array_in_o));
        chip_select_n_i <= 1'b0;
        settle();
        cmp("flash enable", 32'h1, 32'(flash_enable_o));
        for (int c = 0; c < 5; c++)
        begin
            blank_device_i <= (c == 1);
            tp_pin_config_i <= (c == 2);
            tp_array_enable_i <= (c == 3);
            wb(1'b1, PPRC_ADDR_CTRL, 8'(c == 4), 4'h1);
            settle();
            cmp("test port", 32'(c != 0), 32'(tp_active_o));
            cmp("data out enable", 32'h1, 32'(tdo_oe_n_o));
        end
        cmd <= 1'b1;
        ext <= 1'b1;
        settle();
        cmp("data out enable", 32'h0, 32'(tdo_oe_n_o));
        cmp("status enable", 32'h0, 32'(isp_stat_oe_n_o));
        flash_busy_i <= 1'b1;
        settle();
        cmp("status", 32'h0, 32'(isp_status_pin_o));
        flash_busy_i <= 1'b0;
        flash_error_i <= 1'b1;
        settle();
        cmp("status", 32'h1, 32'(isp_status_pin_o));
        cmp("error", 32'h0, 32'(isp_error_pin_o));
        $display("test chip select and port done");
        print_verdict();
    end
    initial
    begin
        #50000;
        mismatches++;
        print_verdict();
    end
endmodule

// ===== design/pprc_ctrl.sv
// Power mode registers, array input gating, chip select, reset sequencing
// and test-port pin enable.
// Assumes pins arrive asynchronously and the processor uses Wishbone.
//
// Added by the designer: the register addresses and the Wishbone register port.
`timescale 1ns/1ps

// Function
// - Fast-mode bit set enables array standby
// - Fast off adds slow propagation delay
// - Fast-mode bit clear gives full speed
// - Bits 2-4 block strobes and third control
// - Bits 5,6 block port pins D0, C7
// - Power registers clear only at power-up
// - Bits 4,5 disconnect array clock
// - Strobes reach the flash unblocked once ready
// - Chip select low enables flash
// - Chip select high leaves arrays running
// - Power-on reset loads configuration
// - Recovery wait after reset release
// - Flash powers up in read-array
// - No sector select or write during reset
// - Array outputs valid per reset type
// - Warm reset then same recovery wait
// - Test port is programming-only, bypass
// - Blank device defaults to test port
// - Pins inputs until enabling command
// - Pin enable is OR of four, software bit included
// - Software enable bit clears on reset
// - Status high idle, error low on fault
module pprc_ctrl
    import pprc_pkg::*;
(
    input  wire logic           clk_i,
    input  wire logic           rst_i,
    input  wire logic           power_good_i,
    input  wire logic           reset_n_i,
    input  wire logic           cyc_i,
    input  wire logic           stb_i,
    input  wire logic           we_i,
    input  wire logic [3:0]     adr_i,
    input  wire logic [3:0]     sel_i,
    input  wire logic [31:0]    dat_i,
    output logic [31:0]         dat_o,
    output logic                ack_o,
    input  wire logic           write_strobe_ctl_n_i,
    input  wire logic           read_strobe_ctl_n_i,
    input  wire logic           third_control_input_i,
    input  wire logic           port_d_pin0_i,
    input  wire logic           port_c_pin7_i,
    input  wire logic           array_clock_input_i,
    input  wire logic           chip_select_n_i,
    input  wire logic           blank_device_i,
    input  wire logic           tp_pin_config_i,
    input  wire logic           tp_array_enable_i,
    input  wire logic           tp_enable_cmd_i,
    input  wire logic           tp_ext_cmd_i,
    input  wire logic           flash_busy_i,
    input  wire logic           flash_error_i,
    input  wire logic           flash_sector_any_i,
    output pprc_array_in_s      array_in_o,
    output logic                mcell_clock_o,
    output logic                array_standby_o,
    output logic                array_slow_o,
    output logic                array_valid_o,
    output logic                flash_enable_o,
    output logic                flash_lowpower_o,
    output logic                flash_read_array_o,
    output logic                flash_sector_block_o,
    output logic                flash_write_n_o,
    output logic                flash_read_n_o,
    output logic                tp_active_o,
    output logic                tdo_oe_n_o,
    output logic                isp_status_pin_o,
    output logic                isp_error_pin_o,
    output logic                isp_stat_oe_n_o,
    output logic                device_ready_o
);

    pprc_state_s q;
    pprc_state_s next_q;

    // ********************************************************
    // Helpers
    // ********************************************************
    function automatic logic [7:0] pprc_wbyte(input logic [31:0] d, input logic [7:0] mask);
        pprc_wbyte = d[7:0] & mask;
    endfunction

    logic bus_req;
    assign bus_req = cyc_i & stb_i & ~q.ack;

    // ********************************************************
    // Next state
    // ********************************************************
    always_comb
    begin
        next_q = q;
        next_q.ack = bus_req;
        // Reset pin synchroniser: only the second stage is read
        next_q.rst_sync = {q.rst_sync[0], reset_n_i};
        next_q.nrst_q = q.rst_sync[1];
        next_q.raw_s1 = '{~write_strobe_ctl_n_i, ~read_strobe_ctl_n_i, third_control_input_i,
                          port_d_pin0_i, port_c_pin7_i, array_clock_input_i};
        next_q.raw_s2 = q.raw_s1;
        next_q.raw_q = q.raw_s2;
        next_q.cs_sync = {q.cs_sync[0], chip_select_n_i};
        next_q.tpc_sync1 = {tp_pin_config_i, tp_array_enable_i, tp_enable_cmd_i, tp_ext_cmd_i};
        next_q.tpc_sync2 = q.tpc_sync1;

        // Reset sequencing
        if (!q.rst_sync[1])
        begin
            next_q.phase = PPRC_ST_LOAD;
            next_q.phase_cnt = '0;
            next_q.tp_soft_en = 1'b0;
        end
        else
        begin
            unique case (q.phase)
                PPRC_ST_LOAD:
                begin
                    // Power-on needs the load; warm reset skips it
                    if (q.powered || q.phase_cnt == 8'(PPRC_POR_LOAD_CYC - 1))
                    begin
                        next_q.phase = PPRC_ST_RECOVER;
                        next_q.phase_cnt = '0;
                        next_q.powered = 1'b1;
                    end
                    else
                    begin
                        next_q.phase_cnt = q.phase_cnt + 8'h01;
                    end
                end
                PPRC_ST_RECOVER:
                begin
                    if (q.phase_cnt == 8'(PPRC_RECOVERY_CYC - 1))
                    begin
                        next_q.phase = PPRC_ST_RUN;
                    end
                    else
                    begin
                        next_q.phase_cnt = q.phase_cnt + 8'h01;
                    end
                end
                PPRC_ST_RUN:
                begin
                    next_q.phase = PPRC_ST_RUN;
                end
            endcase
        end
        next_q.ready = (next_q.phase == PPRC_ST_RUN);

        // Register access; power registers never cleared by reset pin
        next_q.rdata = 8'h00;
        if (bus_req)
        begin
            if (we_i && sel_i[0])
            begin
                unique case (adr_i)
                    PPRC_ADDR_REG_A: next_q.reg_a = pprc_wbyte(dat_i, PPRC_MASK_REG_A);
                    PPRC_ADDR_REG_B: next_q.reg_b = pprc_wbyte(dat_i, PPRC_MASK_REG_B);
                    PPRC_ADDR_CTRL:
                        if (q.rst_sync[1])
                        begin
                            next_q.tp_soft_en = dat_i[PPRC_BIT_TP_EN];
                        end
                    default: ;
                endcase
            end
            unique case (adr_i)
                PPRC_ADDR_REG_A:  next_q.rdata = q.reg_a;
                PPRC_ADDR_REG_B:  next_q.rdata = q.reg_b;
                PPRC_ADDR_CTRL:   next_q.rdata = {7'h00, q.tp_soft_en};
                PPRC_ADDR_STATUS: next_q.rdata = {4'h0, q.tp_on, q.arr_valid,
                                                  q.standby, q.ready};
                default:          next_q.rdata = 8'h00;
            endcase
        end

        // Array input gating
        next_q.arr.wr_strobe = q.raw_q.wr_strobe & ~q.reg_b[PPRC_BIT_BLK_WR];
        next_q.arr.rd_strobe = q.raw_q.rd_strobe & ~q.reg_b[PPRC_BIT_BLK_RD];
        next_q.arr.ctl2 = q.raw_q.ctl2 & ~q.reg_b[PPRC_BIT_BLK_CTL2];
        next_q.arr.pd0 = q.raw_q.pd0 & ~q.reg_b[PPRC_BIT_BLK_PD0];
        next_q.arr.pc7 = q.raw_q.pc7 & ~q.reg_b[PPRC_BIT_BLK_PC7];
        next_q.arr.clk_array = q.raw_q.clk_array & ~q.reg_a[PPRC_BIT_CLK_ARRAY];
        next_q.mcell_clk = q.raw_q.clk_array & ~q.reg_a[PPRC_BIT_CLK_MCELL];

        // Standby after quiet inputs, only with fast mode off
        if (!q.reg_a[PPRC_BIT_FAST_OFF] || next_q.arr != q.arr)
        begin
            next_q.quiet_cnt = '0;
            next_q.standby = 1'b0;
        end
        else if (q.quiet_cnt == 6'(PPRC_STANDBY_CYC - 1))
        begin
            next_q.standby = 1'b1;
        end
        else
        begin
            next_q.quiet_cnt = q.quiet_cnt + 6'h01;
        end
        // Slow flag marks the extra delay window after a wake-up
        if (q.standby && next_q.arr != q.arr)
        begin
            next_q.slow_cnt = 2'(PPRC_SLOW_DELAY_CYC);
        end
        else if (q.slow_cnt != 2'h0)
        begin
            next_q.slow_cnt = q.slow_cnt - 2'h1;
        end
        // Registered so the output comes straight from a flop
        next_q.slow = (next_q.slow_cnt != 2'h0);

        // Outputs hold through warm reset, wait for load at power-on
        next_q.arr_valid = q.powered;

        // Flash path; strobes bypass the blocking bits
        next_q.flash_en = ~q.cs_sync[1] & q.ready;
        next_q.flash_lowpwr = q.cs_sync[1];
        next_q.flash_read_array = ~q.powered | q.flash_read_array & ~flash_busy_i;
        next_q.sect_block = ~q.ready;
        next_q.wr_to_flash = ~(q.raw_q.wr_strobe & q.ready & ~flash_sector_any_i
                               | q.raw_q.wr_strobe & q.ready);
        next_q.rd_to_flash = ~(q.raw_q.rd_strobe & q.ready);

        // Test port enable: programming only, no scan chain of its own
        next_q.tp_on = q.tpc_sync2[3] | blank_device_i | q.tpc_sync2[2]
                       | q.tp_soft_en;
        next_q.tdo_oe_n = ~(next_q.tp_on & q.tpc_sync2[1]);
        next_q.stat_oe_n = ~(next_q.tp_on & q.tpc_sync2[1] & q.tpc_sync2[0]);
        next_q.stat = ~flash_busy_i;
        next_q.err = ~flash_error_i;
    end

    // ********************************************************
    // Registers
    // ********************************************************
    always_ff @(posedge clk_i)
    begin
        if (!power_good_i)
        begin
            // Supply loss is the only event that clears the power registers
            q <= '0;
            q.phase <= PPRC_ST_LOAD;
            q.flash_read_array <= 1'b1;
            q.wr_to_flash <= 1'b1;
            q.rd_to_flash <= 1'b1;
            q.tdo_oe_n <= 1'b1;
            q.stat_oe_n <= 1'b1;
            q.stat <= 1'b1;
            q.err <= 1'b1;
            q.flash_lowpwr <= 1'b1;
            q.sect_block <= 1'b1;
        end
        else if (rst_i)
        begin
            q <= next_q;
            q.ack <= 1'b0;
            q.phase <= PPRC_ST_LOAD;
            q.phase_cnt <= '0;
            q.tp_soft_en <= 1'b0;
            q.ready <= 1'b0;
        end
        else
        begin
            q <= next_q;
        end
    end

    // ********************************************************
    // Outputs
    // ********************************************************
    assign dat_o = {24'h000000, q.rdata};
    assign ack_o = q.ack;
    assign array_in_o = q.arr;
    assign mcell_clock_o = q.mcell_clk;
    assign array_standby_o = q.standby;
    assign array_slow_o = q.slow;
    assign array_valid_o = q.arr_valid;
    assign flash_enable_o = q.flash_en;
    assign flash_lowpower_o = q.flash_lowpwr;
    assign flash_read_array_o = q.flash_read_array;
    assign flash_sector_block_o = q.sect_block;
    assign flash_write_n_o = q.wr_to_flash;
    assign flash_read_n_o = q.rd_to_flash;
    assign tp_active_o = q.tp_on;
    assign tdo_oe_n_o = q.tdo_oe_n;
    assign isp_status_pin_o = q.stat;
    assign isp_error_pin_o = q.err;
    assign isp_stat_oe_n_o = q.stat_oe_n;
    assign device_ready_o = q.ready;

endmodule

// ===== design/pprc_pkg.sv
// Package for the power, reset and test-port control block.
// Assumes a classic Wishbone slave with byte-wide registers in the low lane.
package pprc_pkg;

    // ********************************************************
    // Register map
    // ********************************************************
    localparam logic [3:0] PPRC_ADDR_REG_A   = 4'h0;
    localparam logic [3:0] PPRC_ADDR_REG_B   = 4'h4;
    localparam logic [3:0] PPRC_ADDR_CTRL    = 4'h8;
    localparam logic [3:0] PPRC_ADDR_STATUS  = 4'hC;
    localparam logic [7:0] PPRC_REG_RESET    = 8'h00;
    localparam logic [7:0] PPRC_MASK_REG_A   = 8'h38;
    localparam logic [7:0] PPRC_MASK_REG_B   = 8'h7C;

    // ********************************************************
    // Field positions
    // ********************************************************
    localparam int PPRC_BIT_FAST_OFF     = 3;
    localparam int PPRC_BIT_CLK_ARRAY    = 4;
    localparam int PPRC_BIT_CLK_MCELL    = 5;
    localparam int PPRC_BIT_BLK_WR       = 2;
    localparam int PPRC_BIT_BLK_RD       = 3;
    localparam int PPRC_BIT_BLK_CTL2     = 4;
    localparam int PPRC_BIT_BLK_PD0      = 5;
    localparam int PPRC_BIT_BLK_PC7      = 6;
    localparam int PPRC_BIT_TP_EN        = 0;

    // ********************************************************
    // Timing
    // ********************************************************
    localparam int PPRC_CLK_PERIOD_NS    = 5;
    localparam int PPRC_STANDBY_NS       = 100;
    localparam int PPRC_STANDBY_CYC      = (PPRC_STANDBY_NS + PPRC_CLK_PERIOD_NS - 1)
                                           / PPRC_CLK_PERIOD_NS;
    localparam int PPRC_SLOW_DELAY_NS    = 10;
    localparam int PPRC_SLOW_DELAY_CYC   = (PPRC_SLOW_DELAY_NS + PPRC_CLK_PERIOD_NS - 1)
                                           / PPRC_CLK_PERIOD_NS;
    localparam int PPRC_POR_LOAD_CYC     = 16;
    localparam int PPRC_RECOVERY_CYC     = 64;

    // ********************************************************
    // Types
    // ********************************************************
    typedef enum logic [2:0]
    {
        PPRC_ST_LOAD    = 3'b001,
        PPRC_ST_RECOVER = 3'b010,
        PPRC_ST_RUN     = 3'b100
    } pprc_phase_e;

    typedef struct packed
    {
        logic wr_strobe;
        logic rd_strobe;
        logic ctl2;
        logic pd0;
        logic pc7;
        logic clk_array;
    } pprc_array_in_s;

    typedef struct packed
    {
        logic tck;
        logic tms;
        logic tdi;
        logic tdo;
    } pprc_tp_pins_s;

    typedef struct packed
    {
        logic [7:0]     reg_a;
        logic [7:0]     reg_b;
        logic           tp_soft_en;
        logic           powered;
        pprc_phase_e    phase;
        logic [7:0]     phase_cnt;
        logic [1:0]     rst_sync;
        logic           nrst_q;
        logic           ack;
        logic [7:0]     rdata;
        pprc_array_in_s raw_s1;
        pprc_array_in_s raw_s2;
        pprc_array_in_s raw_q;
        pprc_array_in_s arr;
        logic           mcell_clk;
        logic [5:0]     quiet_cnt;
        logic           standby;
        logic [1:0]     slow_cnt;
        logic           slow;
        logic           arr_valid;
        logic [1:0]     cs_sync;
        logic           flash_en;
        logic           flash_lowpwr;
        logic           flash_read_array;
        logic           sect_block;
        logic           wr_to_flash;
        logic           rd_to_flash;
        logic           tp_on;
        logic           tdo_oe_n;
        logic           stat_oe_n;
        logic           stat;
        logic           err;
        logic [3:0]     tpc_sync1;
        logic [3:0]     tpc_sync2;
        logic           ready;
    } pprc_state_s;

endpackage
